// ---- design/dsi_pkg.sv ----
// shared constants and types for the two-word-burst ddr sram link
package dsi_pkg;
    // lane layout of one data word: four nine-bit lanes
    localparam int DSI_LANE_W = 9;
    localparam int DSI_LANES = 4;
    localparam int DSI_DW = DSI_LANE_W * DSI_LANES;
    // address widths of the organisations, two internal arrays each
    localparam int DSI_AW_X8 = 21;
    localparam int DSI_AW_X9 = 21;
    localparam int DSI_AW_X18 = 20;
    localparam int DSI_AW_X36 = 19;
    // link clock half period in controller clock cycles, and pin update point
    localparam int DSI_KHALF = 4;
    localparam int DSI_KMID = 1;
    // idle pin levels
    localparam logic [DSI_LANES-1:0] DSI_BWS_OFF = 4'hF;
    localparam logic DSI_SEL_OFF = 1'b1;
    typedef enum logic [1:0] {
        DSI_PH_LOW = 2'h1,
        DSI_PH_HIGH = 2'h2
    } dsi_kphase_t;
endpackage : dsi_pkg

// ---- design/dsi_link_if.sv ----
// pin bundle between memory controller and sram device
`timescale 1ns/1ns
interface dsi_link_if
    import dsi_pkg::*;
#(
    parameter int AW = DSI_AW_X36
);
    logic k;
    logic k_n;
    logic c;
    logic c_n;
    logic [AW-1:0] addr;
    logic read_port_select_n;
    logic write_port_select_n;
    logic [DSI_LANES-1:0] byte_lane_write_select_n;
    logic [DSI_DW-1:0] d;
    logic [DSI_DW-1:0] q_o;
    logic q_oe;
    // released read bus reads as zero here; q_oe low stands for the high impedance state
    wire [DSI_DW-1:0] q = q_oe ? q_o : '0;
    logic echo_strobe;
    logic echo_strobe_n;
    logic dll_disable_n;
    logic single_clock_mode;

    modport dev (
        input k, k_n, c, c_n, addr, read_port_select_n, write_port_select_n,
        input byte_lane_write_select_n, d, dll_disable_n, single_clock_mode,
        output q_o, q_oe, echo_strobe, echo_strobe_n
    );
    modport ctl (
        output k, k_n, c, c_n, addr, read_port_select_n, write_port_select_n,
        output byte_lane_write_select_n, d, dll_disable_n, single_clock_mode,
        input q, echo_strobe, echo_strobe_n
    );
endinterface : dsi_link_if

// ---- design/dsi_controller.sv ----
// memory controller end: makes the link clocks, issues accesses, collects bursts
`timescale 1ns/1ns
module dsi_controller
    import dsi_pkg::*;
#(
    parameter int AW = DSI_AW_X36,
    parameter int KHALF = DSI_KHALF
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // static settings
    input wire logic dll_off,
    input wire logic single_clock,
    // access request
    input wire logic rd_req,
    input wire logic [AW-1:0] rd_addr,
    input wire logic wr_req,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DSI_DW-1:0] wr_data0,
    input wire logic [DSI_DW-1:0] wr_data1,
    input wire logic [DSI_LANES-1:0] wr_bws0_n,
    input wire logic [DSI_LANES-1:0] wr_bws1_n,
    output logic req_ready,
    // read return
    output logic [DSI_DW-1:0] rd_data0_q,
    output logic [DSI_DW-1:0] rd_data1_q,
    output logic rd_done_q,
    // link
    dsi_link_if.ctl link
);
    localparam int CW = $clog2(KHALF);
    localparam logic [CW-1:0] CNT_LAST = CW'(KHALF - 1);
    localparam logic [CW-1:0] CNT_MID = CW'(DSI_KMID);

    dsi_kphase_t ph_q, ph_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic [AW-1:0] addr_q, addr_d, wa_q, wa_d;
    logic rps_n_q, rps_n_d, wps_n_q, wps_n_d;
    logic [DSI_DW-1:0] d_q, d_d, d1_q, d1_d;
    logic [DSI_LANES-1:0] bws_q, bws_d, bws1_q, bws1_d;
    logic dll_n_q, scm_q;
    logic e1_q, e2_q, e3_q, rise_q, fall_q;
    logic [DSI_DW-1:0] q1_q, q2_q;
    logic s0_q, s0_d, s1_q, s1_d, s2_q, s2_d;
    logic [DSI_DW-1:0] lo_d, hi_d;
    logic done_d, take;

    // pins change mid phase, away from both capture edges
    assign req_ready = clk_en && (ph_q == DSI_PH_LOW) && (cnt_q == CNT_MID);
    assign take = req_ready;
    assign link.k = (ph_q == DSI_PH_HIGH);
    assign link.k_n = (ph_q != DSI_PH_HIGH);
    assign link.c = (ph_q == DSI_PH_HIGH);
    assign link.c_n = (ph_q != DSI_PH_HIGH);
    assign link.addr = addr_q;
    assign link.read_port_select_n = rps_n_q;
    assign link.write_port_select_n = wps_n_q;
    assign link.byte_lane_write_select_n = bws_q;
    assign link.d = d_q;
    assign link.dll_disable_n = dll_n_q; // RL15
    assign link.single_clock_mode = scm_q; // RL19

    always_comb begin
        cnt_d = cnt_q + CW'(1);
        ph_d = ph_q;
        addr_d = addr_q;
        wa_d = wa_q;
        rps_n_d = rps_n_q;
        wps_n_d = wps_n_q;
        d_d = d_q;
        d1_d = d1_q;
        bws_d = bws_q;
        bws1_d = bws1_q;
        if (cnt_q == CNT_LAST) begin
            cnt_d = '0;
            case (ph_q)
                DSI_PH_LOW: ph_d = DSI_PH_HIGH;
                DSI_PH_HIGH: ph_d = DSI_PH_LOW;
                default: ph_d = DSI_PH_LOW;
            endcase
        end
        if (take) begin
            addr_d = rd_addr; // RL4
            rps_n_d = ~rd_req; // RL9
            wps_n_d = ~wr_req; // RL16
            d_d = wr_data0; // RL17
            bws_d = wr_req ? wr_bws0_n : DSI_BWS_OFF; // RL1
            wa_d = wr_addr;
            d1_d = wr_data1;
            bws1_d = wr_req ? wr_bws1_n : DSI_BWS_OFF;
        end else if (ph_q == DSI_PH_HIGH && cnt_q == CNT_MID) begin
            addr_d = wa_q; // RL4
            d_d = d1_q; // RL17
            bws_d = bws1_q; // RL1
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ph_q <= DSI_PH_LOW;
            cnt_q <= '0;
            addr_q <= '0;
            wa_q <= '0;
            rps_n_q <= DSI_SEL_OFF;
            wps_n_q <= DSI_SEL_OFF;
            d_q <= '0;
            d1_q <= '0;
            bws_q <= DSI_BWS_OFF;
            bws1_q <= DSI_BWS_OFF;
            dll_n_q <= 1'b0;
            scm_q <= 1'b0;
        end else if (clk_en) begin
            ph_q <= ph_d;
            cnt_q <= cnt_d;
            addr_q <= addr_d;
            wa_q <= wa_d;
            rps_n_q <= rps_n_d;
            wps_n_q <= wps_n_d;
            d_q <= d_d;
            d1_q <= d1_d;
            bws_q <= bws_d;
            bws1_q <= bws1_d;
            dll_n_q <= ~dll_off;
            scm_q <= single_clock;
        end
    end

    // read return: echo and data pass two flops; capture one cycle after each echo edge
    always_comb begin
        s0_d = take && rd_req ? 1'b1 : (rise_q ? 1'b0 : s0_q);
        s1_d = rise_q ? s0_q : s1_q;
        s2_d = rise_q ? s1_q : s2_q;
        lo_d = (fall_q && s2_q) ? q2_q : rd_data0_q; // RL18
        hi_d = (rise_q && s2_q) ? q2_q : rd_data1_q; // RL11
        done_d = rise_q && s2_q;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            e1_q <= 1'b0;
            e2_q <= 1'b0;
            e3_q <= 1'b0;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
            q1_q <= '0;
            q2_q <= '0;
            s0_q <= 1'b0;
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            rd_data0_q <= '0;
            rd_data1_q <= '0;
            rd_done_q <= 1'b0;
        end else if (clk_en) begin
            e1_q <= link.echo_strobe; // RL14
            e2_q <= e1_q;
            e3_q <= e2_q;
            rise_q <= e2_q && !e3_q;
            fall_q <= !e2_q && e3_q;
            q1_q <= link.q;
            q2_q <= q1_q;
            s0_q <= s0_d;
            s1_q <= s1_d;
            s2_q <= s2_d;
            rd_data0_q <= lo_d;
            rd_data1_q <= hi_d;
            rd_done_q <= done_d;
        end
    end
endmodule : dsi_controller

// ---- design/dsi_device.sv ----
// sram device end: captures accesses on the link clocks, holds the array, returns bursts
`timescale 1ns/1ns
// What this block does
// RL1 - lane write selects sampled with each data beat
// RL2 - deselected lane leaves stored byte unchanged
// RL3 - each select governs one nine-bit lane
// RL4 - read address at K rise, write at K#
// RL5 - address width follows organisation, two arrays
// RL6 - address ignored when its port deselected
// RL7 - read data launched on both output clocks
// RL8 - outputs high impedance when no read
// RL9 - read select sampled at K rise starts read
// RL10 - pending burst finishes, then outputs tri-state
// RL11 - every read returns exactly two words
// RL12 - accesses begin at K rise capturing inputs
// RL13 - K# rise captures inputs, launches single-clock data
// RL14 - free-running echo clock follows output clock
// RL15 - low dll disable turns off the dll
// RL16 - write select sampled at K rise starts write
// RL17 - write beats captured on K and K#
// RL18 - low word at C#, high word next C
// RL19 - static single clock mode picks timing clocks
module dsi_device
    import dsi_pkg::*;
#(
    parameter int AW = DSI_AW_X36
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // status toward local logic
    output logic dll_on_q,
    output logic wr_event_q,
    output logic rd_event_q,
    // link
    dsi_link_if.dev link
);
    localparam int DEPTH = 2 ** AW; // RL5

    // merge one beat into a stored word lane by lane
    function automatic logic [DSI_DW-1:0] lane_merge(
        input logic [DSI_DW-1:0] old_w,
        input logic [DSI_DW-1:0] new_w,
        input logic [DSI_LANES-1:0] sel_n
    );
        logic [DSI_DW-1:0] r;
        r = old_w;
        for (int i = 0; i < DSI_LANES; i++) begin
            if (!sel_n[i]) begin
                r[i*DSI_LANE_W +: DSI_LANE_W] = new_w[i*DSI_LANE_W +: DSI_LANE_W]; // RL3
            end
        end
        return r; // RL2
    endfunction : lane_merge

    // the two internal arrays: first and second word of every location
    logic [DSI_DW-1:0] mem_lo [DEPTH];
    logic [DSI_DW-1:0] mem_hi [DEPTH];

    logic ce1_q, ce_k_q;
    logic scm1_q, scm_q;
    logic oclk, oclk_n;
    // k rise domain
    logic rd_q, rd_d, wr_q, wr_d;
    logic [AW-1:0] ra_q, ra_d;
    logic [DSI_DW-1:0] d0_q, d0_d;
    logic [DSI_LANES-1:0] bws0_q, bws0_d;
    logic [DSI_DW-1:0] lo_q, lo_d, hi_q, hi_d;
    logic rv_q, rv_d;
    logic rtog_q, rtog_d;
    // k# rise domain
    logic wtog_q, wtog_d;
    // output clock domain
    logic [DSI_DW-1:0] qn_q, qp_q;
    logic oen_q, oep_q;
    // local clock domain
    logic dll1_q;
    logic [2:0] ws_q, rs_q;

    // static mode and enable levels enter the link domain through two flops
    always_ff @(posedge link.k or negedge arst_n) begin
        if (!arst_n) begin
            ce1_q <= 1'b0;
            ce_k_q <= 1'b0;
            scm1_q <= 1'b0;
            scm_q <= 1'b0;
        end else begin
            ce1_q <= clk_en;
            ce_k_q <= ce1_q;
            scm1_q <= link.single_clock_mode;
            scm_q <= scm1_q; // RL19
        end
    end

    // output timing clocks; mode must not change while running
    assign oclk = scm_q ? link.k : link.c; // RL7
    assign oclk_n = scm_q ? link.k_n : link.c_n; // RL13
    assign link.echo_strobe = oclk; // RL14
    assign link.echo_strobe_n = oclk_n; // RL14

    always_comb begin
        rd_d = !link.read_port_select_n; // RL9
        wr_d = !link.write_port_select_n; // RL16
        ra_d = ra_q;
        d0_d = d0_q;
        bws0_d = DSI_BWS_OFF;
        if (rd_d) begin
            ra_d = link.addr; // RL4
        end
        if (wr_d) begin
            d0_d = link.d; // RL17
            bws0_d = link.byte_lane_write_select_n; // RL1
        end
        // burst of two words fetched one K cycle after the request
        lo_d = rd_q ? mem_lo[ra_q] : lo_q; // RL11
        hi_d = rd_q ? mem_hi[ra_q] : hi_q; // RL11
        rv_d = rd_q;
        rtog_d = rtog_q ^ rd_q;
    end

    always_ff @(posedge link.k or negedge arst_n) begin
        if (!arst_n) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            ra_q <= '0;
            d0_q <= '0;
            bws0_q <= DSI_BWS_OFF;
            lo_q <= '0;
            hi_q <= '0;
            rv_q <= 1'b0;
            rtog_q <= 1'b0;
        end else if (ce_k_q) begin
            rd_q <= rd_d; // RL12
            wr_q <= wr_d; // RL12
            ra_q <= ra_d; // RL6
            d0_q <= d0_d;
            bws0_q <= bws0_d;
            lo_q <= lo_d;
            hi_q <= hi_d;
            rv_q <= rv_d;
            rtog_q <= rtog_d;
        end
    end

    // second beat and write address at K# rise; a deselected port writes nothing
    always_comb begin
        wtog_d = wtog_q ^ wr_q;
    end

    always_ff @(posedge link.k_n or negedge arst_n) begin
        if (!arst_n) begin
            wtog_q <= 1'b0;
        end else if (ce_k_q) begin
            wtog_q <= wtog_d;
        end
    end

    always_ff @(posedge link.k_n) begin
        if (ce_k_q && wr_q) begin
            mem_lo[link.addr] <= lane_merge(mem_lo[link.addr], d0_q, bws0_q); // RL13
            mem_hi[link.addr] <= lane_merge(mem_hi[link.addr], link.d,
                link.byte_lane_write_select_n); // RL17
        end
    end

    // low word from C# rise, high word from the next C rise, then release
    always_ff @(posedge oclk_n or negedge arst_n) begin
        if (!arst_n) begin
            qn_q <= '0;
            oen_q <= 1'b0;
        end else if (ce_k_q) begin
            qn_q <= lo_q; // RL18
            oen_q <= rv_q; // RL8
        end
    end

    always_ff @(posedge oclk or negedge arst_n) begin
        if (!arst_n) begin
            qp_q <= '0;
            oep_q <= 1'b0;
        end else if (ce_k_q) begin
            qp_q <= hi_q; // RL18
            oep_q <= oen_q; // RL10
        end
    end

    // each phase shows the flop launched on its own rising edge
    assign link.q_o = oclk ? qp_q : qn_q; // RL7
    assign link.q_oe = oclk ? oep_q : oen_q; // RL8

    // status back in the local clock: dll level and access events
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dll1_q <= 1'b0;
            dll_on_q <= 1'b0;
            ws_q <= '0;
            rs_q <= '0;
            wr_event_q <= 1'b0;
            rd_event_q <= 1'b0;
        end else if (clk_en) begin
            dll1_q <= link.dll_disable_n;
            dll_on_q <= dll1_q; // RL15
            ws_q <= {ws_q[1:0], wtog_q};
            rs_q <= {rs_q[1:0], rtog_q};
            wr_event_q <= ws_q[2] ^ ws_q[1];
            rd_event_q <= rs_q[2] ^ rs_q[1];
        end
    end
endmodule : dsi_device

// ---- bench/dsi_link_assertions.sv ----
// concurrent checks on the link pins between the two ends
`timescale 1ns/1ns
module dsi_link_assertions
    import dsi_pkg::*;
#(
    parameter int AW = DSI_AW_X36
) (
    // clocks and reset
    input wire logic clk,
    input wire logic arst_n,
    input wire logic k,
    input wire logic k_n,
    input wire logic c,
    input wire logic c_n,
    // controller pins
    input wire logic [AW-1:0] addr,
    input wire logic read_port_select_n,
    input wire logic write_port_select_n,
    input wire logic [DSI_LANES-1:0] byte_lane_write_select_n,
    input wire logic [DSI_DW-1:0] d,
    // device pins
    input wire logic [DSI_DW-1:0] q_o,
    input wire logic q_oe,
    input wire logic echo_strobe
);
    property p_rd_on;
        @(posedge k) disable iff (!arst_n) !read_port_select_n |-> ##2 q_oe;
    endproperty
    a_rd_on: assert property (p_rd_on) else $error("read burst missing");
    property p_rd_off;
        @(posedge k) disable iff (!arst_n) read_port_select_n |-> ##2 !q_oe;
    endproperty
    a_rd_off: assert property (p_rd_off) else $error("q driven without read");
    property p_burst;
        @(posedge clk) disable iff (!arst_n) $rose(q_oe) |-> q_oe [*8];
    endproperty
    a_burst: assert property (p_burst) else $error("burst too short");
    property p_oe_edge;
        @(posedge clk) disable iff (!arst_n) $changed(q_oe) |-> $rose(c_n);
    endproperty
    a_oe_edge: assert property (p_oe_edge) else $error("q enable off edge");
    property p_word_edge;
        @(posedge clk) disable iff (!arst_n)
            $changed(q_o) && q_oe && $past(q_oe) |-> $rose(c) || $rose(c_n);
    endproperty
    a_word_edge: assert property (p_word_edge) else $error("q word off edge");
    property p_echo_rise;
        @(posedge clk) disable iff (!arst_n) $rose(c) |-> ##[0:2] echo_strobe;
    endproperty
    a_echo_rise: assert property (p_echo_rise) else $error("echo late rise");
    property p_echo_fall;
        @(posedge clk) disable iff (!arst_n) $fell(c) |-> ##[0:2] !echo_strobe;
    endproperty
    a_echo_fall: assert property (p_echo_fall) else $error("echo late fall");
    property p_d_setup;
        @(posedge clk) disable iff (!arst_n)
            $changed(d) || $changed(byte_lane_write_select_n) |-> !$rose(k) && !$rose(k_n);
    endproperty
    a_d_setup: assert property (p_d_setup) else $error("data at capture");
    property p_sel_setup;
        @(posedge clk) disable iff (!arst_n)
            $changed({read_port_select_n, write_port_select_n}) |-> !$rose(k);
    endproperty
    a_sel_setup: assert property (p_sel_setup) else $error("select at capture");
    property p_addr_setup;
        @(posedge clk) disable iff (!arst_n) $changed(addr) |-> !$rose(k) && !$rose(k_n);
    endproperty
    a_addr_setup: assert property (p_addr_setup) else $error("addr at capture");
    c_b2b: cover property (@(posedge k) !read_port_select_n ##1 !read_port_select_n);
    c_both: cover property (@(posedge k) !read_port_select_n && !write_port_select_n);
    c_part: cover property (@(posedge k) !write_port_select_n && byte_lane_write_select_n != 4'h0);
endmodule : dsi_link_assertions

// ---- bench/dual_port_ddr_sram_interface_bench.sv ----
// self-checking bench for both ends of the ddr sram link
`timescale 1ns/1ns
module dual_port_ddr_sram_interface_bench;
    import dsi_pkg::*;
    localparam int AW = 6;
    // one row: write, then the two words that the read back of that address should give
    typedef struct packed {
        logic [AW-1:0] a;
        logic [DSI_DW-1:0] d0;
        logic [DSI_DW-1:0] d1;
        logic [DSI_LANES-1:0] b0;
        logic [DSI_LANES-1:0] b1;
        logic [DSI_DW-1:0] e0;
        logic [DSI_DW-1:0] e1;
    } dsi_row_t;
    logic clk = 1'b0;
    // starts high so that the first reset is a real falling edge for the link flops
    logic arst_n = 1'b1;
    logic dll_off = 1'b0;
    logic single_clock = 1'b0;
    logic rd_req = 1'b0;
    logic wr_req = 1'b0;
    logic [AW-1:0] rd_addr = '0;
    logic [AW-1:0] wr_addr = '0;
    logic [DSI_DW-1:0] wr_data0 = '0;
    logic [DSI_DW-1:0] wr_data1 = '0;
    logic [DSI_LANES-1:0] wr_bws0_n = DSI_BWS_OFF;
    logic [DSI_LANES-1:0] wr_bws1_n = DSI_BWS_OFF;
    logic req_ready, rd_done_q, dll_on_q, wr_event_q, rd_event_q;
    logic [DSI_DW-1:0] rd_data0_q, rd_data1_q;
    logic [DSI_DW-1:0] mem_lo [2**AW];
    logic [DSI_DW-1:0] mem_hi [2**AW];
    dsi_row_t rows [6];
    dsi_row_t hw;
    int error_cnt = 0;
    int compares = 0;
    int n_wr = 0, n_rd = 0, ev_wr = 0, ev_rd = 0, ev_done = 0;

    always #10 clk = ~clk;
    always @(posedge clk) begin
        if (wr_event_q === 1'b1) ev_wr <= ev_wr + 1;
        if (rd_event_q === 1'b1) ev_rd <= ev_rd + 1;
        if (rd_done_q === 1'b1) ev_done <= ev_done + 1;
    end

    dsi_link_if #(.AW(AW)) dsi_link_if_inst ();
    dsi_controller #(.AW(AW), .KHALF(DSI_KHALF)) dsi_controller_inst (
        .clk(clk), .arst_n(arst_n), .clk_en(1'b1), .dll_off(dll_off),
        .single_clock(single_clock), .rd_req(rd_req), .rd_addr(rd_addr), .wr_req(wr_req),
        .wr_addr(wr_addr), .wr_data0(wr_data0), .wr_data1(wr_data1), .wr_bws0_n(wr_bws0_n),
        .wr_bws1_n(wr_bws1_n), .req_ready(req_ready), .rd_data0_q(rd_data0_q),
        .rd_data1_q(rd_data1_q), .rd_done_q(rd_done_q), .link(dsi_link_if_inst));
    dsi_device #(.AW(AW)) dsi_device_inst (
        .clk(clk), .arst_n(arst_n), .clk_en(1'b1), .dll_on_q(dll_on_q),
        .wr_event_q(wr_event_q), .rd_event_q(rd_event_q), .link(dsi_link_if_inst));
    dsi_link_assertions #(.AW(AW)) dsi_link_assertions_inst (
        .clk(clk), .arst_n(arst_n), .k(dsi_link_if_inst.k), .k_n(dsi_link_if_inst.k_n),
        .c(dsi_link_if_inst.c), .c_n(dsi_link_if_inst.c_n), .addr(dsi_link_if_inst.addr),
        .read_port_select_n(dsi_link_if_inst.read_port_select_n),
        .write_port_select_n(dsi_link_if_inst.write_port_select_n),
        .byte_lane_write_select_n(dsi_link_if_inst.byte_lane_write_select_n),
        .d(dsi_link_if_inst.d), .q_o(dsi_link_if_inst.q_o), .q_oe(dsi_link_if_inst.q_oe),
        .echo_strobe(dsi_link_if_inst.echo_strobe));

    task check(input logic [DSI_DW-1:0] seen, input logic [DSI_DW-1:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [DSI_DW-1:0] lanes(input logic [DSI_DW-1:0] o,
        input logic [DSI_DW-1:0] n, input logic [DSI_LANES-1:0] s);
        for (int i = 0; i < DSI_LANES; i++) begin
            if (!s[i]) o[i*DSI_LANE_W +: DSI_LANE_W] = n[i*DSI_LANE_W +: DSI_LANE_W];
        end
        return o;
    endfunction : lanes

    task issue(input logic rd, input logic [AW-1:0] ra, input logic wr, input dsi_row_t w);
        int t;
        t = 0;
        do begin
            @(negedge clk);
            t++;
        end while (req_ready !== 1'b1 && t < 40);
        if (t >= 40) error_cnt++;
        rd_req = rd;
        rd_addr = ra;
        wr_req = wr;
        wr_addr = w.a;
        wr_data0 = w.d0;
        wr_data1 = w.d1;
        wr_bws0_n = w.b0;
        wr_bws1_n = w.b1;
        if (wr) begin
            mem_lo[w.a] = lanes(mem_lo[w.a], w.d0, w.b0);
            mem_hi[w.a] = lanes(mem_hi[w.a], w.d1, w.b1);
            n_wr++;
        end
        if (rd) n_rd++;
        @(negedge clk);
        rd_req = 1'b0;
        wr_req = 1'b0;
    endtask : issue

    task wait_rd(input logic [DSI_DW-1:0] e0, input logic [DSI_DW-1:0] e1);
        int t;
        t = 0;
        do begin
            @(negedge clk);
            t++;
        end while (rd_done_q !== 1'b1 && t < 100);
        if (t >= 100) error_cnt++;
        check(rd_data0_q, e0);
        check(rd_data1_q, e1);
    endtask : wait_rd

    task do_reset;
        arst_n = 1'b0;
        repeat (16) @(negedge clk);
        check(req_ready, 1'b0);
        check(rd_done_q, 1'b0);
        check(dsi_link_if_inst.q_oe, 1'b0);
        check(dsi_link_if_inst.byte_lane_write_select_n, DSI_BWS_OFF);
        arst_n = 1'b1;
        repeat (40) @(negedge clk);
    endtask : do_reset

    task conclude;
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    initial begin
        #400000;
        error_cnt++;
        conclude();
    end

    initial begin
        rows[0] = '{6'h05, 36'hF_0123_4567, 36'h8_89AB_CDEF, 4'h0, 4'h0,
            36'hF_0123_4567, 36'h8_89AB_CDEF};
        rows[1] = '{6'h05, 36'hA_AAAA_AAAA, 36'h5_5555_5555, 4'hE, 4'h7,
            36'hF_0123_44AA, 36'h5_51AB_CDEF};
        rows[2] = '{6'h05, 36'h0_0000_0000, 36'hF_FFFF_FFFF, 4'hF, 4'hF,
            36'hF_0123_44AA, 36'h5_51AB_CDEF};
        rows[3] = '{6'h05, 36'h1_1111_1111, 36'h2_2222_2222, 4'hD, 4'hB,
            36'hF_0121_10AA, 36'h5_5223_CDEF};
        rows[4] = '{6'h00, 36'h3_C3C3_C3C3, 36'h4_4B4B_4B4B, 4'h0, 4'h0,
            36'h3_C3C3_C3C3, 36'h4_4B4B_4B4B};
        rows[5] = '{6'h3F, 36'h7_0F0F_0F0F, 36'h6_6E6E_6E6E, 4'h0, 4'h0,
            36'h7_0F0F_0F0F, 36'h6_6E6E_6E6E};
        hw = '{6'h09, 36'h9_8765_4321, 36'h1_2345_6789, 4'h0, 4'h0,
            36'h9_8765_4321, 36'h1_2345_6789};
        #1;
        do_reset();
        foreach (rows[i]) begin
            issue(1'b0, 6'h00, 1'b1, rows[i]);
            issue(1'b1, rows[i].a, 1'b0, rows[i]);
            wait_rd(rows[i].e0, rows[i].e1);
        end
        // read and write in one period, then reads back to back
        issue(1'b1, 6'h05, 1'b1, hw);
        wait_rd(mem_lo[6'h05], mem_hi[6'h05]);
        issue(1'b1, 6'h09, 1'b0, rows[0]);
        issue(1'b1, 6'h3F, 1'b0, rows[0]);
        wait_rd(hw.e0, hw.e1);
        wait_rd(rows[5].e0, rows[5].e1);
        // both ports deselected: bus contents ignored
        repeat (4) issue(1'b0, 6'h05, 1'b0, rows[2]);
        repeat (40) @(negedge clk);
        dll_off = 1'b1;
        repeat (40) @(negedge clk);
        check(dll_on_q, 1'b0);
        dll_off = 1'b0;
        repeat (40) @(negedge clk);
        check(dll_on_q, 1'b1);
        single_clock = 1'b1;
        do_reset();
        issue(1'b0, 6'h00, 1'b1, rows[0]);
        issue(1'b1, 6'h05, 1'b0, rows[0]);
        wait_rd(mem_lo[6'h05], mem_hi[6'h05]);
        repeat (40) @(negedge clk);
        check(ev_wr, n_wr);
        check(ev_rd, n_rd);
        check(ev_done, n_rd);
        conclude();
    end
endmodule : dual_port_ddr_sram_interface_bench
